// ===== fault_alert_regs.vh
// Constants for the fault alert and sync trigger block.
// Assumes inclusion by bare name from design files in the same folder.
`ifndef FAULT_ALERT_REGS_VH
`define FAULT_ALERT_REGS_VH

`define EMCY_ID_BASE 11'h080
`define SYNC_ID_RESET 11'h080
`define EMCY_LEN 4'h8

`define CODE_NONE 16'h0000
`define CODE_OVERCURRENT 16'h2310
`define CODE_OVERRUN 16'h8110
`define CODE_PASSIVE 16'h8120
`define CODE_GUARD 16'h8130
`define CODE_BUSOFF 16'h8140
`define CODE_PDO_LEN 16'h8210
`define CODE_PDO_LONG 16'h8220
`define CODE_DEV_POS 16'h8400
`define CODE_DEV_VEL 16'h8611

`define MASK_OVERCURRENT 16'h0001
`define MASK_DEVIATION 16'h0002
`define MASK_PASSIVE 16'h0040
`define MASK_OVERRUN 16'h0080
`define MASK_GUARD 16'h0100
`define MASK_BUSOFF 16'h0200
`define MASK_PDO_LONG 16'h2000
`define MASK_PDO_LEN 16'h4000
`define MASK_RESET 16'hffff

`define CAT_CURRENT 8'h02
`define CAT_COMM 8'h10
`define CAT_DEVIATION 8'h20

`define TXTYPE_MAX 8'hf0
`define NMT_START 8'h01

`define OFF_MASK 4'h0
`define OFF_CATEGORY 4'h1
`define OFF_VENDOR 4'h2
`define OFF_CUR_LIMIT 4'h3
`define OFF_DELAY 4'h4
`define OFF_DEV_LIMIT 4'h5
`define OFF_SYNC_ID 4'h6
`define OFF_RX_TYPE 4'h7
`define OFF_TX_TYPE 4'h8
`define OFF_STATUS 4'h9
`define OFF_LAST_CODE 4'ha

`define TYPE_RESET 8'hff
`define DELAY_RESET 16'h0000
`define DEV_LIMIT_RESET 16'hffff

`endif

// ===== fault_alert_and_sync_trigger.v
// Emergency frame generator and SYNC handler of a CAN motion node.
// Assumes a frame controller that accepts a frame with emcyValid/emcyReady
// and delivers each received frame identifier as a one-cycle rxFrameValid.
//
// Contract
// - Faults are announced unprompted by an emergency frame.
// - Emergency frame identifier is 0x80 plus node ID, eight bytes long.
// - Payload: code low first, category, vendor bits low first, zeros.
// - Category byte bit-coded per error type; last value readable.
// - A fault is sent only when its emergency mask bit is set.
// - Overcurrent raised only after limit exceeded longer than delay time.
// - Overrun 0x8110 mask 0x0080, passive 0x8120 mask 0x0040, category bit 4.
// - Guard failure 0x8130 mask 0x0100; bus-off recovery 0x8140 mask 0x0200.
// - Bad PDO length 0x8210 mask 0x4000; long PDO 0x8220 mask 0x2000.
// - Speed deviation over limit: 0x8611 velocity mode, 0x8400 position mode.
// - Deviation fault clears on drive state change or new move.
// - SYNC carries no data and triggers synchronous PDOs.
// - SYNC identifier is programmable, 0x80 after reset.
// - SYNC acts only on PDOs configured as synchronous.
// - Synchronous receive PDO command is held until next SYNC.
// - Receive types 1 to 240 behave like type 0.
// - Synchronous transmit PDO sent with current data upon SYNC.
// - Nodes may be grouped by types 1 to 240.
// - PDO activity begins only after start-remote-node command 0x01.
// - Guard or heartbeat timeout sends emergency 0x8130 by default.
`timescale 1ns/10ps
`default_nettype none
`include "fault_alert_regs.vh"

module fault_alert_and_sync_trigger #(
    parameter CW = 16 // Current measurement width
) (
    input wire clk, // Clock, 50 MHz
    input wire nrst, // Asynchronous reset, active low
    input wire [6:0] nodeId, // Node address
    input wire [3:0] addr, // Register address
    input wire [15:0] wdata, // Register write data
    input wire wr, // Write strobe
    input wire rd, // Read strobe
    output reg [15:0] rdata, // Read data, cycle after rd
    input wire [CW-1:0] current, // Measured current
    input wire [15:0] speedDev, // Magnitude of speed deviation
    input wire velMode, // High in velocity mode, low in position mode
    input wire driveStateChange, // Pulse: drive state machine switched
    input wire moveStart, // Pulse: new positioning started
    input wire canOverrun, // Pulse: receive overrun
    input wire canPassive, // Pulse: entered error passive
    input wire guardFail, // Pulse: guarding or heartbeat timeout
    input wire busOffRecovered, // Pulse: recovered from bus off
    input wire pdoLenError, // Pulse: PDO rejected for length
    input wire pdoLenExceeded, // Pulse: PDO length exceeded
    input wire rxFrameValid, // Pulse: frame received
    input wire [10:0] rxFrameId, // Received identifier
    input wire [3:0] rxFrameLen, // Received data length
    input wire nmtStart, // Pulse: start-remote-node for this node
    input wire nmtStop, // Pulse: leave operational state
    input wire rxPdoValid, // Pulse: receive PDO command arrived
    input wire [31:0] rxPdoData, // Receive PDO command
    input wire [31:0] txPdoSource, // Live values for transmit PDO
    output reg rxCmdValid, // Pulse: execute receive PDO command
    output reg [31:0] rxCmdData, // Command to execute
    output reg txPdoValid, // Pulse: send transmit PDO
    output reg [31:0] txPdoData, // Transmit PDO payload
    output reg emcyValid, // Emergency frame pending
    input wire emcyReady, // Frame controller takes frame
    output reg [10:0] emcyId, // Emergency identifier
    output wire [3:0] emcyLen, // Emergency data length
    output reg [63:0] emcyData // Emergency payload, byte 0 in low bits
);

//------------------------------------------------------------
// Register map
//------------------------------------------------------------
localparam [3:0] A_MASK = `OFF_MASK;
localparam [3:0] A_CATEGORY = `OFF_CATEGORY;
localparam [3:0] A_VENDOR = `OFF_VENDOR;
localparam [3:0] A_CUR_LIMIT = `OFF_CUR_LIMIT;
localparam [3:0] A_DELAY = `OFF_DELAY;
localparam [3:0] A_DEV_LIMIT = `OFF_DEV_LIMIT;
localparam [3:0] A_SYNC_ID = `OFF_SYNC_ID;
localparam [3:0] A_RX_TYPE = `OFF_RX_TYPE;
localparam [3:0] A_TX_TYPE = `OFF_TX_TYPE;
localparam [3:0] A_STATUS = `OFF_STATUS;
localparam [3:0] A_LAST_CODE = `OFF_LAST_CODE;

reg [15:0] emcyMask;
reg [7:0] category;
reg [15:0] vendorBits;
reg [CW-1:0] curLimit;
reg [15:0] delayTime;
reg [15:0] devLimit;
reg [10:0] syncId;
reg [7:0] rxType;
reg [7:0] txType;
reg [15:0] lastCode;
reg operational;

function isSync;
    input [7:0] t;
    begin
        isSync = (t <= `TXTYPE_MAX);
    end
endfunction

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        emcyMask <= `MASK_RESET;
        curLimit <= {CW{1'b1}};
        delayTime <= `DELAY_RESET;
        devLimit <= `DEV_LIMIT_RESET;
        syncId <= `SYNC_ID_RESET;
        rxType <= `TYPE_RESET;
        txType <= `TYPE_RESET;
    end else if (wr) begin
        if (addr == A_MASK) begin
            emcyMask <= wdata;
        end else if (addr == A_CUR_LIMIT) begin
            curLimit <= wdata[CW-1:0];
        end else if (addr == A_DELAY) begin
            delayTime <= wdata;
        end else if (addr == A_DEV_LIMIT) begin
            devLimit <= wdata;
        end else if (addr == A_SYNC_ID) begin
            syncId <= wdata[10:0];
        end else if (addr == A_RX_TYPE) begin
            rxType <= wdata[7:0];
        end else if (addr == A_TX_TYPE) begin
            txType <= wdata[7:0];
        end
    end
end

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        rdata <= 16'h0000;
    end else if (rd) begin
        if (addr == A_MASK) begin
            rdata <= emcyMask;
        end else if (addr == A_CATEGORY) begin
            rdata <= {8'h00, category};
        end else if (addr == A_VENDOR) begin
            rdata <= vendorBits;
        end else if (addr == A_CUR_LIMIT) begin
            rdata <= {{(16-CW){1'b0}}, curLimit};
        end else if (addr == A_DELAY) begin
            rdata <= delayTime;
        end else if (addr == A_DEV_LIMIT) begin
            rdata <= devLimit;
        end else if (addr == A_SYNC_ID) begin
            rdata <= {5'h00, syncId};
        end else if (addr == A_RX_TYPE) begin
            rdata <= {8'h00, rxType};
        end else if (addr == A_TX_TYPE) begin
            rdata <= {8'h00, txType};
        end else if (addr == A_STATUS) begin
            rdata <= {15'h0000, operational};
        end else if (addr == A_LAST_CODE) begin
            rdata <= lastCode;
        end else begin
            rdata <= 16'h0000;
        end
    end else begin
        rdata <= 16'h0000;
    end
end

//------------------------------------------------------------
// Fault detection
//------------------------------------------------------------
reg [15:0] overTimer;
reg overFault;
reg devFault;
wire overNow = (current > curLimit);
wire overRise = overNow && (overTimer == delayTime) && !overFault;
wire devRise = (speedDev > devLimit) && !devFault &&
    !driveStateChange && !moveStart;

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        overTimer <= 16'h0000;
        overFault <= 1'b0;
        devFault <= 1'b0;
    end else begin
        if (!overNow) begin
            overTimer <= 16'h0000;
            overFault <= 1'b0;
        end else if (overTimer != delayTime) begin
            overTimer <= overTimer + 16'h0001;
        end else begin
            overFault <= 1'b1;
        end
        if (devRise) begin
            devFault <= 1'b1;
        end else if (driveStateChange || moveStart) begin
            devFault <= 1'b0;
        end
    end
end

//------------------------------------------------------------
// Emergency event latch and frame build
//------------------------------------------------------------
// Pending events; set wins over the clear of the event loaded into a frame
reg [7:0] pend;
wire [15:0] mdev = emcyMask & `MASK_DEVIATION;
wire [7:0] evt = {
    pdoLenExceeded && |(emcyMask & `MASK_PDO_LONG),
    pdoLenError && |(emcyMask & `MASK_PDO_LEN),
    busOffRecovered && |(emcyMask & `MASK_BUSOFF),
    guardFail && |(emcyMask & `MASK_GUARD),
    canPassive && |(emcyMask & `MASK_PASSIVE),
    canOverrun && |(emcyMask & `MASK_OVERRUN),
    devRise && |mdev,
    overRise && |(emcyMask & `MASK_OVERCURRENT)
};
// Persistent faults only; the comm events are one-shot
wire [15:0] activeBits = (overFault ? `MASK_OVERCURRENT : 16'h0000) |
    (devFault ? `MASK_DEVIATION : 16'h0000);
reg hadFault;
reg clearPend;
reg [2:0] sel;
reg [15:0] selCode;
reg [7:0] selCat;
integer i;

always @* begin
    sel = 3'd0;
    for (i = 7; i >= 0; i = i - 1) begin
        if (pend[i]) begin
            sel = i[2:0];
        end
    end
    selCat = `CAT_COMM;
    case (sel)
        3'd0: begin
            selCode = `CODE_OVERCURRENT;
            selCat = `CAT_CURRENT;
        end
        3'd1: begin
            selCode = velMode ? `CODE_DEV_VEL : `CODE_DEV_POS;
            selCat = `CAT_DEVIATION;
        end
        3'd2: selCode = `CODE_OVERRUN;
        3'd3: selCode = `CODE_PASSIVE;
        3'd4: selCode = `CODE_GUARD;
        3'd5: selCode = `CODE_BUSOFF;
        3'd6: selCode = `CODE_PDO_LEN;
        default: selCode = `CODE_PDO_LONG;
    endcase
end

assign emcyLen = `EMCY_LEN;

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        pend <= 8'h00;
        hadFault <= 1'b0;
        clearPend <= 1'b0;
        emcyValid <= 1'b0;
        emcyId <= `EMCY_ID_BASE;
        emcyData <= 64'h0000000000000000;
        category <= 8'h00;
        vendorBits <= 16'h0000;
        lastCode <= `CODE_NONE;
    end else begin
        vendorBits <= activeBits;
        if (activeBits != 16'h0000) begin
            hadFault <= 1'b1;
        end else if (hadFault) begin
            hadFault <= 1'b0;
            clearPend <= 1'b1;
        end
        if (emcyValid && emcyReady) begin
            emcyValid <= 1'b0;
        end else if (!emcyValid && pend != 8'h00) begin
            emcyValid <= 1'b1;
            emcyId <= `EMCY_ID_BASE + {4'h0, nodeId};
            // Live fault bits; they carry overcurrent and deviation, never the comm faults
            emcyData <= {24'h000000, activeBits, selCat, selCode};
            category <= selCat;
            lastCode <= selCode;
        end else if (!emcyValid && clearPend) begin
            clearPend <= 1'b0;
            emcyValid <= 1'b1;
            emcyId <= `EMCY_ID_BASE + {4'h0, nodeId};
            emcyData <= 64'h0000000000000000;
            category <= 8'h00;
            lastCode <= `CODE_NONE;
        end
        if (!emcyValid && pend != 8'h00) begin
            pend <= (pend & ~(8'h01 << sel)) | evt;
        end else begin
            pend <= pend | evt;
        end
    end
end

//------------------------------------------------------------
// SYNC handling and synchronous PDOs
//------------------------------------------------------------
reg rxHeld;
reg [7:0] syncCount;
wire syncSeen = rxFrameValid && (rxFrameId == syncId) &&
    (rxFrameLen == 4'h0);
wire syncAct = syncSeen && operational;
wire [7:0] nextCount = syncCount + 8'h01;

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        operational <= 1'b0;
        rxHeld <= 1'b0;
        rxCmdData <= 32'h00000000;
        rxCmdValid <= 1'b0;
        txPdoValid <= 1'b0;
        txPdoData <= 32'h00000000;
        syncCount <= 8'h00;
    end else begin
        rxCmdValid <= 1'b0;
        txPdoValid <= 1'b0;
        if (nmtStart) begin
            operational <= 1'b1;
        end else if (nmtStop) begin
            operational <= 1'b0;
        end
        if (rxPdoValid && operational) begin
            rxCmdData <= rxPdoData;
            if (isSync(rxType)) begin
                rxHeld <= 1'b1;
            end else begin
                rxCmdValid <= 1'b1;
            end
        end
        if (syncAct && rxHeld && !(rxPdoValid && operational)) begin
            rxHeld <= 1'b0;
            rxCmdValid <= 1'b1;
        end
        if (syncAct && isSync(txType)) begin
            if (txType == 8'h00 || nextCount >= txType) begin
                syncCount <= 8'h00;
                txPdoValid <= 1'b1;
                txPdoData <= txPdoSource;
            end else begin
                syncCount <= nextCount;
            end
        end
    end
end

endmodule // fault_alert_and_sync_trigger
`default_nettype wire

// ===== fault_alert_and_sync_trigger_monitor.sv
// Assertion checker for the fault alert and sync trigger block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module fault_alert_and_sync_trigger_monitor #(
    parameter CW = 16
) (
    input wire logic clk, // Clock
    input wire logic nrst, // Reset, active low
    input wire logic [6:0] nodeId, // Node address
    input wire logic rd, // Read strobe
    input wire logic [15:0] rdata, // Read data
    input wire logic rxFrameValid, // Frame strobe
    input wire logic [3:0] rxFrameLen, // Frame length
    input wire logic rxPdoValid, // Receive PDO strobe
    input wire logic rxCmdValid, // Command execute
    input wire logic txPdoValid, // Transmit PDO
    input wire logic emcyValid, // Frame offered
    input wire logic emcyReady, // Frame taken
    input wire logic [10:0] emcyId, // Frame identifier
    input wire logic [3:0] emcyLen, // Frame length
    input wire logic [63:0] emcyData // Frame payload
);
    // ----------------------------------------
    // Emergency frame, SYNC and read data relations
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_len_fixed: assert property (emcyLen == 4'h8)
        else $error("emergency length not eight");
    a_emcy_ident: assert property (
        emcyValid |-> emcyId == 11'h080 + nodeId)
        else $error("emergency identifier wrong");
    a_tail_zero: assert property (
        emcyValid |-> emcyData[63:40] == 24'h0)
        else $error("emergency tail bytes not zero");
    a_frame_hold: assert property (emcyValid && !emcyReady
        |=> emcyValid && $stable(emcyData)) else $error("frame withdrawn");
    a_comm_category: assert property (
        emcyValid && emcyData[15:10] == 6'h20 |-> emcyData[23:16] == 8'h10)
        else $error("comm category wrong");
    a_dev_category: assert property (
        emcyValid && (emcyData[15:0] == 16'h8611
        || emcyData[15:0] == 16'h8400) |-> emcyData[23:16] == 8'h20)
        else $error("deviation category wrong");
    a_clear_frame: assert property (
        emcyValid && emcyData[15:0] == 16'h0 |-> emcyData == 64'h0)
        else $error("clear frame not empty");
    a_read_window: assert property (!rd |=> rdata == 16'h0)
        else $error("read data outside window");
    a_tx_on_sync: assert property (
        txPdoValid |-> $past(rxFrameValid) && $past(rxFrameLen) == 4'h0)
        else $error("tx without sync");
    a_cmd_cause: assert property (
        rxCmdValid |-> $past(rxFrameValid) || $past(rxPdoValid))
        else $error("command without cause");
    c_frame: cover property (emcyValid && emcyReady);
    c_tx: cover property (txPdoValid);
    c_cmd: cover property (rxCmdValid);
endmodule // fault_alert_and_sync_trigger_monitor
bind fault_alert_and_sync_trigger fault_alert_and_sync_trigger_monitor
    #(.CW(CW)) mon (.clk, .nrst, .nodeId, .rd, .rdata, .rxFrameValid,
    .rxFrameLen, .rxPdoValid, .rxCmdValid, .txPdoValid, .emcyValid,
    .emcyReady, .emcyId, .emcyLen, .emcyData);
`default_nettype wire

// ===== frame_master_model.sv
// Frame controller and network master seen from the block.
// Assumes the testbench sets the stall and calls sendFrame.
`timescale 1ns/10ps
`default_nettype none
module frame_master_model (
    input wire logic clk, // Clock
    input wire logic nrst, // Reset, active low
    input wire logic [1:0] stall, // Cycles before taking a frame
    input wire logic emcyValid, // Frame offered
    input wire logic [10:0] emcyId, // Offered identifier
    input wire logic [63:0] emcyData, // Offered payload
    output logic emcyReady, // Frame taken
    output logic rxFrameValid = 1'b0, // Received frame strobe
    output logic [10:0] rxFrameId = 11'h7ff, // Received identifier
    output logic [3:0] rxFrameLen = 4'hf // Received length
);
    logic [63:0] got;
    logic [10:0] gotId;
    logic [1:0] wcnt;
    integer nFrames;
    // ----------------------------------------
    // Takes each frame whole after a stall
    // ----------------------------------------
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            emcyReady <= 1'b0;
            wcnt <= 2'h0;
            nFrames <= 0;
        end else if (emcyValid && emcyReady) begin
            emcyReady <= 1'b0;
            wcnt <= 2'h0;
            got <= emcyData;
            gotId <= emcyId;
            nFrames <= nFrames + 1;
        end else if (emcyValid) begin
            emcyReady <= (wcnt >= stall);
            wcnt <= wcnt + 2'h1;
        end
    end
    // Lines change outside frames; SYNC has length 0
    task automatic sendFrame(input logic [10:0] id, input logic [3:0] len);
        @(posedge clk);
        rxFrameValid <= 1'b1;
        rxFrameId <= id;
        rxFrameLen <= len;
        @(posedge clk);
        rxFrameValid <= 1'b0;
        rxFrameId <= ~id;
        rxFrameLen <= ~len;
    endtask
endmodule // frame_master_model
`default_nettype wire

// ===== fault_alert_and_sync_trigger_tb.sv
// Self-checking testbench for the fault alert and sync trigger block.
// Assumes the partner model and checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module fault_alert_and_sync_trigger_tb;
    logic clk, nrst = 1'b0, wr = 1'b0, rd = 1'b0, velMode = 1'b0;
    logic rxPdoValid = 1'b0, rxCmdValid, txPdoValid, emcyValid, emcyReady;
    logic rxFrameValid;
    logic [8:0] ev = 9'h0;
    logic [1:0] stall = 2'h0;
    logic [3:0] addr = 4'h0, rxFrameLen, emcyLen;
    logic [6:0] nodeId = 7'h0;
    logic [10:0] emcyId, rxFrameId;
    logic [15:0] wdata = 16'h0, current = 16'h0, speedDev = 16'h0;
    logic [15:0] rdata, limit;
    logic [31:0] rxPdoData = 32'h0, txPdoSource = 32'h0, d;
    logic [31:0] rxCmdData, txPdoData, cmdSeen, txSeen;
    logic [63:0] emcyData;
    integer seed = 66, nMismatch = 0, totalChecks = 0;
    integer nCmd = 0, nTx = 0, cyc = 0, i, k;
    logic [15:0] cd [6] = '{16'h8110, 16'h8120, 16'h8130, 16'h8140,
        16'h8210, 16'h8220};
    logic [15:0] mb [6] = '{16'h0080, 16'h0040, 16'h0100, 16'h0200,
        16'h4000, 16'h2000};
    logic [3:0] ra [6] = '{4'h0, 4'h6, 4'h7, 4'h8, 4'h9, 4'hf};
    logic [15:0] rv [6] = '{16'hffff, 16'h0080, 16'h00ff, 16'h00ff,
        16'h0000, 16'h0000};

    fault_alert_and_sync_trigger DUT (.clk, .nrst, .nodeId, .addr, .wdata,
        .wr, .rd, .rdata, .current, .speedDev, .velMode,
        .driveStateChange(ev[6]), .moveStart(ev[7]), .canOverrun(ev[0]),
        .canPassive(ev[1]), .guardFail(ev[2]), .busOffRecovered(ev[3]),
        .pdoLenError(ev[4]), .pdoLenExceeded(ev[5]), .rxFrameValid,
        .rxFrameId, .rxFrameLen, .nmtStart(ev[8]), .nmtStop(1'b0),
        .rxPdoValid, .rxPdoData, .txPdoSource, .rxCmdValid, .rxCmdData,
        .txPdoValid, .txPdoData, .emcyValid, .emcyReady, .emcyId, .emcyLen,
        .emcyData);
    frame_master_model fm (.clk, .nrst, .stall, .emcyValid, .emcyId,
        .emcyData, .emcyReady, .rxFrameValid, .rxFrameId, .rxFrameLen);

    // ----------------------------------------
    // Clock, timeout and output capture
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rxCmdValid) begin
            nCmd <= nCmd + 1;
            cmdSeen <= rxCmdData;
        end
        if (txPdoValid) begin
            nTx <= nTx + 1;
            txSeen <= txPdoData;
        end
        if (cyc == 20000) begin
            nMismatch = nMismatch + 1;
            final_report;
        end
    end

    function automatic logic [74:0] frame(input logic [15:0] code,
        input logic [7:0] cat, input logic [15:0] vend);
        return {11'h080 + nodeId, 24'h0, vend, cat, code};
    endfunction
    task automatic chk(input string what, input logic [79:0] seen, exp);
        totalChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic regWr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdChk(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", rdata, v);
    endtask
    task automatic pulse(input integer n);
        @(posedge clk);
        ev[n] <= 1'b1;
        @(posedge clk);
        ev <= 9'h0;
    endtask
    task automatic expectFrame(input logic [15:0] code, input logic [7:0] c,
        input logic [15:0] v);
        integer n0, t;
        n0 = fm.nFrames;
        for (t = 0; t < 60 && fm.nFrames == n0; t++) @(posedge clk);
        chk("frame", {fm.gotId, fm.got}, frame(code, c, v));
    endtask
    task automatic noFrame;
        integer n0;
        n0 = fm.nFrames;
        repeat (12) @(posedge clk);
        chk("noframe", fm.nFrames, n0);
    endtask
    task automatic syncs(input integer n, input logic [10:0] id);
        repeat (n) fm.sendFrame(id, 4'h0);
        repeat (3) @(posedge clk);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        nodeId = 7'($random(seed));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        regWr(4'hf, 16'h1234);
        for (i = 0; i < 6; i++) rdChk(ra[i], rv[i]);
        regWr(4'h8, 16'h0001);
        syncs(1, 11'h080);
        chk("txStopped", nTx, 0);
        pulse(8);
        rdChk(4'h9, 16'h0001);
        $display("test reset and start done");
        for (i = 0; i < 6; i++) begin
            stall <= 2'($random(seed));
            regWr(4'h0, ~mb[i]);
            pulse(i);
            noFrame();
            regWr(4'h0, mb[i]);
            pulse(i);
            expectFrame(cd[i], 8'h10, 16'h0);
            rdChk(4'h1, 16'h0010);
        end
        regWr(4'h0, 16'hffff);
        $display("test comm faults done");
        limit = 16'($random(seed)) & 16'h7fff;
        regWr(4'h3, limit);
        regWr(4'h4, 16'h0003);
        current <= limit + 16'h1;
        repeat (3) @(posedge clk);
        current <= limit;
        noFrame();
        current <= limit + 16'h1;
        expectFrame(16'h2310, 8'h02, 16'h0001);
        current <= limit;
        expectFrame(16'h0000, 8'h00, 16'h0000);
        regWr(4'h5, 16'h0100);
        k = $random(seed);
        velMode <= k[0];
        speedDev <= 16'h0101;
        expectFrame(k[0] ? 16'h8611 : 16'h8400, 8'h20, 16'h0002);
        rdChk(4'h2, 16'h0002);
        rdChk(4'ha, k[0] ? 16'h8611 : 16'h8400);
        speedDev <= 16'h0000;
        pulse(6 + k[1]);
        expectFrame(16'h0000, 8'h00, 16'h0000);
        $display("test persistent faults done");
        regWr(4'h7, 16'(1 + {$random(seed)} % 240));
        d = $random(seed);
        rxPdoData <= d;
        rxPdoValid <= 1'b1;
        @(posedge clk);
        rxPdoValid <= 1'b0;
        repeat (5) @(posedge clk);
        chk("cmdHeld", nCmd, 0);
        syncs(1, 11'h080);
        chk("cmd", {nCmd, cmdSeen}, {32'd1, d});
        regWr(4'h8, 16'h0002);
        d = $random(seed);
        syncs(2, 11'h080);
        txPdoSource <= d;
        syncs(2, 11'h080);
        chk("txEvery2", {nTx, txSeen}, {32'd3, d});
        regWr(4'h6, 16'h0123);
        fm.sendFrame(11'h080, 4'h0);
        fm.sendFrame(11'h123, 4'h1);
        regWr(4'h8, 16'h0001);
        syncs(1, 11'h123);
        chk("syncId", nTx, 4);
        regWr(4'h8, 16'h00ff);
        syncs(1, 11'h123);
        chk("asyncTx", nTx, 4);
        $display("test sync done");
        final_report;
    end
endmodule // fault_alert_and_sync_trigger_tb
`default_nettype wire
